/* rlvd_params.svh */
// constants for the wakeup timer and low-voltage control register block
`ifndef RLVD_PARAMS_SVH
`define RLVD_PARAMS_SVH

`define RLVD_ADDR_W 8
`define RLVD_OFS_WAKEUP 8'h00
`define RLVD_OFS_LOWV 8'h01

`define RLVD_WK_FLAG 7
`define RLVD_WK_ACK 6
`define RLVD_WK_CLKSEL 5
`define RLVD_WK_IRQEN 4
`define RLVD_WK_UNUSED 3
`define RLVD_WK_DLY_HI 2
`define RLVD_WK_DLY_LO 0

`define RLVD_LV_FLAG 7
`define RLVD_LV_ACK 6
`define RLVD_LV_IRQEN 5
`define RLVD_LV_RSTEN 4
`define RLVD_LV_STOPEN 3
`define RLVD_LV_DETEN 2
`define RLVD_LV_RSVD 1
`define RLVD_LV_BANDGAP_BUFFER_ENABLE 0

`define RLVD_WK_RESET 8'h00
`define RLVD_LV_RESET 8'h1c

`define RLVD_CLK_PERIOD_NS 10
`define RLVD_OSC_PERIOD_NS 1000000

`define RLVD_INT_MS_1 8
`define RLVD_INT_MS_2 32
`define RLVD_INT_MS_3 64
`define RLVD_INT_MS_4 128
`define RLVD_INT_MS_5 256
`define RLVD_INT_MS_6 512
`define RLVD_INT_MS_7 1024
`define RLVD_OSC_TICK_MS 1

`define RLVD_EXT_DIV_1 256
`define RLVD_EXT_DIV_2 1024
`define RLVD_EXT_DIV_3 2048
`define RLVD_EXT_DIV_4 4096
`define RLVD_EXT_DIV_5 8192
`define RLVD_EXT_DIV_6 16384
`define RLVD_EXT_DIV_7 32768

`endif

/* rlvd_pkg.sv */
// types shared by the wakeup timer and low-voltage control block
`default_nettype none
package rlvd_pkg;
  typedef logic [7:0] rlvd_byte_t;
  typedef logic [2:0] rlvd_delay_t;
  typedef logic [15:0] rlvd_count_t;
  typedef enum logic {rlvd_src_int, rlvd_src_ext} rlvd_src_t;
endpackage : rlvd_pkg
`default_nettype wire

/* rlvd_regs.sv */
// wakeup timer and low-voltage control register bank
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "rlvd_params.svh"
`default_nettype none
// Summary of operation
// RULE_01 - timer end sets timeout flag bit 7
// RULE_02 - writing ack bit 6 clears timeout flag
// RULE_03 - bit 5 selects internal or crystal clock
// RULE_04 - bit 4 enables wakeup interrupt
// RULE_05 - delay code zero keeps timer off
// RULE_06 - internal delays 8 ms to 1.024 s
// RULE_07 - crystal delays divide 256 to 32768
// RULE_08 - bit 3 reads zero, register resets zero
// RULE_09 - enabled detection sets low-voltage flag bit 7
// RULE_10 - ack bit 6 clears low-voltage flag
// RULE_11 - bit 5 raises low-voltage interrupt
// RULE_12 - bit 4 forces reset on low voltage
// RULE_13 - bit 3 keeps detection during stop
// RULE_14 - bit 2 enables low-voltage detection logic
// RULE_15 - bits 4:2 write once, reset to one
// RULE_16 - software writes zero to bit 1
// RULE_17 - bit 0 drives bandgap buffer enable
// RULE_18 - timer restarts each timeout or code change
// RULE_19 - wakeup interrupt while flag and enable set
module rlvd_regs #(
  parameter int OSC_DIV = `RLVD_OSC_PERIOD_NS / `RLVD_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`RLVD_ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic ext_clk_in,
  input wire logic low_volt_trip_in,
  input wire logic stop_mode,
  output logic wakeup_irq,
  output logic low_volt_irq,
  output logic low_volt_reset_req,
  output logic bandgap_buffer_enable
);

  localparam int OSC_W = $clog2(OSC_DIV + 1);
  // reset images kept whole so each field is cut by index, never by a shift
  localparam rlvd_pkg::rlvd_byte_t WK_RST = `RLVD_WK_RESET;
  localparam rlvd_pkg::rlvd_byte_t LV_RST = `RLVD_LV_RESET;

  rlvd_tmr_if tif ();

  // wakeup timer register fields
  logic wk_flag_ff;
  rlvd_pkg::rlvd_src_t wk_src_ff;
  logic wk_irqen_ff;
  rlvd_pkg::rlvd_delay_t wk_dly_ff;
  logic restart_ff;

  // low-voltage register fields
  logic lv_flag_ff;
  logic lv_irqen_ff;
  logic lv_rsten_ff;
  logic lv_stopen_ff;
  logic lv_deten_ff;
  logic lv_bandgap_buffer_enable_ff;
  logic lv_once_ff;

  // outputs
  rlvd_pkg::rlvd_byte_t rd_data_ff;
  logic wk_irq_ff;
  logic lv_irq_ff;
  logic lv_reset_ff;

  // clock and pin conditioning
  logic [OSC_W-1:0] osc_cnt_ff;
  logic tick_int_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_prev_ff;
  logic tick_ext_ff;
  logic trip_meta_ff;
  logic trip_sync_ff;

  logic wr_wk;
  logic wr_lv;
  logic rd_wk;
  logic rd_lv;
  logic lv_event;
  rlvd_pkg::rlvd_delay_t nxt_dly;
  rlvd_pkg::rlvd_src_t nxt_src;

  assign wr_wk = wr_en && addr == `RLVD_OFS_WAKEUP;
  assign wr_lv = wr_en && addr == `RLVD_OFS_LOWV;
  assign rd_wk = rd_en && addr == `RLVD_OFS_WAKEUP;
  assign rd_lv = rd_en && addr == `RLVD_OFS_LOWV;
  assign nxt_dly = wr_data[`RLVD_WK_DLY_HI:`RLVD_WK_DLY_LO];
  assign nxt_src = wr_data[`RLVD_WK_CLKSEL] ? rlvd_pkg::rlvd_src_ext : rlvd_pkg::rlvd_src_int;

  // internal 1 kHz oscillator stands in as a divided enable pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_cnt_ff <= '0;
      tick_int_ff <= 1'b0;
    end else begin
      tick_int_ff <= osc_cnt_ff == OSC_W'(OSC_DIV - 1);
      osc_cnt_ff <= (osc_cnt_ff == OSC_W'(OSC_DIV - 1)) ? '0 : osc_cnt_ff + 1'b1;
    end
  end

  // crystal clock is sampled, so it must stay well below clk/4
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      tick_ext_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_clk_in;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
      tick_ext_ff <= ext_sync_ff && !ext_prev_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trip_meta_ff <= 1'b0;
      trip_sync_ff <= 1'b0;
    end else begin
      trip_meta_ff <= low_volt_trip_in;
      trip_sync_ff <= trip_meta_ff;
    end
  end

  // RULE_03 clock select storage
  // RULE_04 irq enable storage
  // RULE_08 reset to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wk_src_ff <= rlvd_pkg::rlvd_src_int;
      wk_irqen_ff <= WK_RST[`RLVD_WK_IRQEN];
      wk_dly_ff <= WK_RST[`RLVD_WK_DLY_HI:`RLVD_WK_DLY_LO];
    end else if (wr_wk) begin
      wk_src_ff <= nxt_src;
      wk_irqen_ff <= wr_data[`RLVD_WK_IRQEN];
      wk_dly_ff <= nxt_dly;
    end
  end

  // RULE_18 code change restarts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= wr_wk && (nxt_dly != wk_dly_ff || nxt_src != wk_src_ff);
    end
  end

  // RULE_01 timeout sets flag
  // RULE_02 ack clears, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wk_flag_ff <= 1'b0;
    end else if (tif.timeout) begin
      wk_flag_ff <= 1'b1;
    end else if (wr_wk && wr_data[`RLVD_WK_ACK]) begin
      wk_flag_ff <= 1'b0;
    end
  end

  // RULE_19 irq follows flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wk_irq_ff <= 1'b0;
    end else begin
      wk_irq_ff <= wk_flag_ff && wk_irqen_ff;
    end
  end

  assign tif.clk_src = wk_src_ff;
  assign tif.delay_sel = wk_dly_ff;
  assign tif.restart = restart_ff;
  assign tif.tick_int = tick_int_ff;
  assign tif.tick_ext = tick_ext_ff;

  rlvd_wakeup_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // RULE_15 write-once controls
  // RULE_16 bit 1 ignored on write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lv_once_ff <= 1'b0;
      lv_rsten_ff <= LV_RST[`RLVD_LV_RSTEN];
      lv_stopen_ff <= LV_RST[`RLVD_LV_STOPEN];
      lv_deten_ff <= LV_RST[`RLVD_LV_DETEN];
    end else if (wr_lv && !lv_once_ff) begin
      lv_once_ff <= 1'b1;
      lv_rsten_ff <= wr_data[`RLVD_LV_RSTEN];
      lv_stopen_ff <= wr_data[`RLVD_LV_STOPEN];
      lv_deten_ff <= wr_data[`RLVD_LV_DETEN];
    end
  end

  // RULE_17 bandgap buffer bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lv_irqen_ff <= LV_RST[`RLVD_LV_IRQEN];
      lv_bandgap_buffer_enable_ff <= LV_RST[`RLVD_LV_BANDGAP_BUFFER_ENABLE];
    end else if (wr_lv) begin
      lv_irqen_ff <= wr_data[`RLVD_LV_IRQEN];
      lv_bandgap_buffer_enable_ff <= wr_data[`RLVD_LV_BANDGAP_BUFFER_ENABLE];
    end
  end

  // RULE_13 stop gating
  // RULE_14 detect enable gating
  assign lv_event = lv_deten_ff && trip_sync_ff && (!stop_mode || lv_stopen_ff);

  // RULE_09 event sets flag
  // RULE_10 ack clears, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lv_flag_ff <= 1'b0;
    end else if (lv_event) begin
      lv_flag_ff <= 1'b1;
    end else if (wr_lv && wr_data[`RLVD_LV_ACK]) begin
      lv_flag_ff <= 1'b0;
    end
  end

  // RULE_11 low-voltage irq
  // RULE_12 reset request gating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lv_irq_ff <= 1'b0;
      lv_reset_ff <= 1'b0;
    end else begin
      lv_irq_ff <= lv_flag_ff && lv_irqen_ff;
      lv_reset_ff <= lv_flag_ff && lv_rsten_ff && lv_deten_ff;
    end
  end

  // RULE_08 unused bits read zero
  // RULE_02 ack reads zero
  // RULE_10 ack reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else if (rd_wk) begin
      rd_data_ff <= {wk_flag_ff, 1'b0, wk_src_ff == rlvd_pkg::rlvd_src_ext, wk_irqen_ff, 1'b0, wk_dly_ff};
    end else if (rd_lv) begin
      rd_data_ff <= {lv_flag_ff, 1'b0, lv_irqen_ff, lv_rsten_ff, lv_stopen_ff, lv_deten_ff, 1'b0, lv_bandgap_buffer_enable_ff};
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  assign rd_data = rd_data_ff;
  assign wakeup_irq = wk_irq_ff;
  assign low_volt_irq = lv_irq_ff;
  assign low_volt_reset_req = lv_reset_ff;
  assign bandgap_buffer_enable = lv_bandgap_buffer_enable_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wk_flag_set: assert property (tif.timeout |=> wk_flag_ff) // RULE_01
    else $error("timeout did not set wakeup flag");

  a_wk_ack_clear: assert property ( // RULE_02
    wr_wk && wr_data[`RLVD_WK_ACK] && !tif.timeout |=> !wk_flag_ff)
    else $error("wakeup ack did not clear flag");

  a_wk_set_wins: assert property (wr_wk && wr_data[`RLVD_WK_ACK] && tif.timeout |=> wk_flag_ff) // RULE_02
    else $error("timeout lost under ack");

  a_wk_rd_zero: assert property (rd_wk |=> !rd_data[`RLVD_WK_ACK] && !rd_data[`RLVD_WK_UNUSED]) // RULE_08
    else $error("wakeup read shows nonzero in unused bits");

  a_wk_clk_sel: assert property ( // RULE_03
    wr_wk |=> (rd_wk |=> rd_data[`RLVD_WK_CLKSEL] == $past(wr_data[`RLVD_WK_CLKSEL], 2)))
    else $error("clock select readback wrong");

  a_wk_irq_track: assert property (wk_flag_ff && wk_irqen_ff |=> wakeup_irq) // RULE_19
    else $error("wakeup irq missing");

  a_wk_irq_gate: assert property (!wk_irqen_ff |=> !wakeup_irq) // RULE_04
    else $error("wakeup irq while disabled");

  a_wk_restart: assert property (wr_wk && nxt_dly != wk_dly_ff |=> restart_ff ##1 !tif.timeout) // RULE_18
    else $error("delay change did not restart");

  a_lv_flag_set: assert property (lv_event |=> lv_flag_ff) // RULE_09
    else $error("low-voltage event did not set flag");

  a_lv_no_detect: assert property (!lv_deten_ff && !lv_flag_ff && !wr_lv |=> !lv_flag_ff) // RULE_14
    else $error("flag set while detection off");

  a_lv_stop_mask: assert property ( // RULE_13
    stop_mode && !lv_stopen_ff && !lv_flag_ff |=> !lv_flag_ff)
    else $error("flag set in stop without stop enable");

  a_lv_ack_clear: assert property (wr_lv && wr_data[`RLVD_LV_ACK] && !lv_event |=> !lv_flag_ff) // RULE_10
    else $error("low-voltage ack did not clear flag");

  a_lv_irq: assert property (lv_flag_ff && lv_irqen_ff |=> low_volt_irq) // RULE_11
    else $error("low-voltage irq missing");

  a_lv_reset_req: assert property ( // RULE_12
    lv_flag_ff && lv_rsten_ff && lv_deten_ff |=> low_volt_reset_req)
    else $error("low-voltage reset not requested");

  a_lv_no_reset: assert property (!lv_rsten_ff || !lv_deten_ff |=> !low_volt_reset_req) // RULE_12
    else $error("reset requested while disabled");

  a_lv_write_once: assert property ( // RULE_15
    lv_once_ff && wr_lv |=> $stable(lv_rsten_ff) && $stable(lv_stopen_ff) && $stable(lv_deten_ff))
    else $error("write-once bits changed twice");

  a_lv_once_load: assert property ( // RULE_15
    wr_lv && !lv_once_ff |=> lv_once_ff && lv_deten_ff == $past(wr_data[`RLVD_LV_DETEN]))
    else $error("first low-voltage write not taken");

  a_wk_irq_drop: assert property (!wk_flag_ff |=> !wakeup_irq) // RULE_19
    else $error("wakeup irq without flag");

  a_wk_irqen_load: assert property (wr_wk |=> wk_irqen_ff == $past(wr_data[`RLVD_WK_IRQEN])) // RULE_04
    else $error("wakeup irq enable not loaded");

  a_lv_irq_gate: assert property (!lv_irqen_ff |=> !low_volt_irq) // RULE_11
    else $error("low-voltage irq while disabled");

  a_lv_bandgap_buffer_enable: assert property (wr_lv |=> bandgap_buffer_enable == $past(wr_data[`RLVD_LV_BANDGAP_BUFFER_ENABLE])) // RULE_17
    else $error("bandgap enable not loaded");

  a_lv_rd_zero: assert property (rd_lv |=> !rd_data[`RLVD_LV_ACK] && !rd_data[`RLVD_LV_RSVD]) // RULE_10
    else $error("low-voltage read shows nonzero in unused bits");

  c_wk_timeout_irq: cover property (tif.timeout && wk_irqen_ff ##2 wakeup_irq);
  c_lv_reset: cover property (lv_event ##2 low_volt_reset_req);
  c_lv_once_block: cover property (wr_lv ##1 (wr_lv && lv_once_ff));
  c_wk_ack_race: cover property (wr_wk && wr_data[`RLVD_WK_ACK] && tif.timeout);

endmodule : rlvd_regs
`default_nettype wire

/* rlvd_regs_tb.sv */
// self-checking bench for the wakeup timer and low-voltage register bank
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module rlvd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short prescaler keeps the longest internal delay near 4k cycles
  localparam int OSC = 4;
  localparam int EXT_CYC = 8;
  logic clk, rst_n, wr_en, rd_en, ext_clk_in, low_volt_trip_in, stop_mode, ext_run;
  logic [7:0] addr, wr_data, rd_data;
  logic wakeup_irq, low_volt_irq, low_volt_reset_req, bandgap_buffer_enable, irq_q;
  int fail_count, checked, cyc, rises, last_rise;
  int int_ms [7] = '{8, 32, 64, 128, 256, 512, 1024};
  logic [7:0] lv_cfg [5] = '{8'h34, 8'h34, 8'h2c, 8'h1c, 8'h38};
  logic lv_stop [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [2:0] lv_exp [5] = '{3'h0, 3'h7, 3'h6, 3'h5, 3'h0};

  rlvd_regs #(.OSC_DIV(OSC)) i_rlvd_regs (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .ext_clk_in(ext_clk_in), .low_volt_trip_in(low_volt_trip_in),
    .stop_mode(stop_mode), .wakeup_irq(wakeup_irq), .low_volt_irq(low_volt_irq),
    .low_volt_reset_req(low_volt_reset_req), .bandgap_buffer_enable(bandgap_buffer_enable)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // crystal stands still unless a test runs it; offset keeps its edges off the clk edges
  initial begin
    ext_clk_in = 1'b0;
    #3;
    forever #40 ext_clk_in = ext_run ? ~ext_clk_in : ext_clk_in;
  end

  // rising edges of the wakeup request, stamped in clk cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_q <= wakeup_irq;
    if (wakeup_irq === 1'b1 && irq_q !== 1'b1) begin
      rises <= rises + 1;
      last_rise <= cyc;
    end
  end

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, exp)
  endtask : rd_chk

  task automatic wait_rise(input int limit);
    int base;
    int n;
    base = rises;
    n = 0;
    while (rises == base && n < limit) begin
      @(posedge clk);
      n++;
    end
    `CHK(rises != base, 1'b1)
  endtask : wait_rise

  // period is taken between two timeouts so the prescaler phase drops out
  task automatic tmr_period(input logic [7:0] cfg, input int exp_cyc);
    int r1;
    wr(8'h00, cfg | 8'h40);
    wait_rise(2 * exp_cyc + 40);
    r1 = last_rise;
    wr(8'h00, cfg);
    rd_chk(8'h00, cfg | 8'h80);
    wr(8'h00, cfg | 8'h40);
    rd_chk(8'h00, cfg);
    `CHK(wakeup_irq, 1'b0)
    wait_rise(exp_cyc + 40);
    `CHK(last_rise - r1, exp_cyc)
  endtask : tmr_period

  task automatic test_reset();
    do_reset();
    `CHK({wakeup_irq, low_volt_irq, low_volt_reset_req, bandgap_buffer_enable}, 4'h0)
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h1c);
    wr(8'h05, 8'hff);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h01, 8'h1c);
    $display("test reset done");
  endtask : test_reset

  task automatic test_wakeup_int();
    for (int c = 1; c <= 7; c++) begin
      tmr_period(8'h10 | 8'(c), int_ms[c - 1] * OSC);
    end
    $display("test internal wakeup done");
  endtask : test_wakeup_int

  task automatic test_wakeup_ext();
    wr(8'h00, 8'h71);
    repeat (200) @(posedge clk);
    `CHK(wakeup_irq, 1'b0)
    ext_run = 1'b1;
    tmr_period(8'h31, 256 * EXT_CYC);
    tmr_period(8'h32, 1024 * EXT_CYC);
    ext_run = 1'b0;
    $display("test external wakeup done");
  endtask : test_wakeup_ext

  task automatic test_delay_off();
    wr(8'h00, 8'h41);
    repeat (80) @(posedge clk);
    rd_chk(8'h00, 8'h81);
    `CHK(wakeup_irq, 1'b0)
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h58);
    repeat (200) @(posedge clk);
    rd_chk(8'h00, 8'h10);
    `CHK(wakeup_irq, 1'b0)
    $display("test delay off done");
  endtask : test_delay_off

  task automatic test_lowv_ack();
    do_reset();
    @(posedge clk);
    low_volt_trip_in <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(low_volt_reset_req, 1'b1)
    `CHK(low_volt_irq, 1'b0)
    wr(8'h01, 8'h7d);
    rd_chk(8'h01, 8'hbd);
    `CHK({low_volt_irq, bandgap_buffer_enable}, 2'h3)
    @(posedge clk);
    low_volt_trip_in <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'h01, 8'h60);
    rd_chk(8'h01, 8'h3c);
    `CHK({low_volt_irq, low_volt_reset_req, bandgap_buffer_enable}, 3'h0)
    $display("test low-voltage ack done");
  endtask : test_lowv_ack

  // each case needs a fresh reset because the enables are write-once
  task automatic test_lowv_table();
    for (int i = 0; i < 5; i++) begin
      do_reset();
      wr(8'h01, lv_cfg[i]);
      @(posedge clk);
      stop_mode <= lv_stop[i];
      low_volt_trip_in <= 1'b1;
      repeat (8) @(posedge clk);
      rd_chk(8'h01, lv_cfg[i] | {lv_exp[i][2], 7'h00});
      `CHK({low_volt_irq, low_volt_reset_req}, lv_exp[i][1:0])
      @(posedge clk);
      low_volt_trip_in <= 1'b0;
      stop_mode <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("test low-voltage table done");
  endtask : test_lowv_table

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // tests need about 40k cycles; give up after 60k
  initial begin
    #600000;
    fail_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    low_volt_trip_in = 1'b0;
    stop_mode = 1'b0;
    ext_run = 1'b0;
    test_reset();
    test_wakeup_int();
    test_wakeup_ext();
    test_delay_off();
    test_lowv_ack();
    test_lowv_table();
    summarize();
  end
endmodule : rlvd_regs_tb
`default_nettype wire

/* rlvd_tmr_if.sv */
// link between the register bank and the wakeup timer
`default_nettype none
interface rlvd_tmr_if;
  rlvd_pkg::rlvd_src_t clk_src;
  rlvd_pkg::rlvd_delay_t delay_sel;
  logic restart;
  logic tick_int;
  logic tick_ext;
  logic timeout;
  modport ctrl (output clk_src, output delay_sel, output restart, output tick_int, output tick_ext, input timeout);
  modport tmr (input clk_src, input delay_sel, input restart, input tick_int, input tick_ext, output timeout);
endinterface : rlvd_tmr_if
`default_nettype wire

/* rlvd_wakeup_timer.sv */
// periodic wakeup counter with selectable source and delay
`include "rlvd_params.svh"
`default_nettype none
module rlvd_wakeup_timer (
  input wire logic clk,
  input wire logic rst_n,
  rlvd_tmr_if.tmr tif
);

  rlvd_pkg::rlvd_count_t cnt_ff;
  logic timeout_ff;
  logic tick;
  rlvd_pkg::rlvd_count_t limit;

  function automatic rlvd_pkg::rlvd_count_t dly_limit(input rlvd_pkg::rlvd_src_t src,
                                                      input rlvd_pkg::rlvd_delay_t code);
    logic ext;
    ext = (src == rlvd_pkg::rlvd_src_ext);
    case (code)
      3'h1: dly_limit = ext ? 16'(`RLVD_EXT_DIV_1) : 16'(`RLVD_INT_MS_1 / `RLVD_OSC_TICK_MS);
      3'h2: dly_limit = ext ? 16'(`RLVD_EXT_DIV_2) : 16'(`RLVD_INT_MS_2 / `RLVD_OSC_TICK_MS);
      3'h3: dly_limit = ext ? 16'(`RLVD_EXT_DIV_3) : 16'(`RLVD_INT_MS_3 / `RLVD_OSC_TICK_MS);
      3'h4: dly_limit = ext ? 16'(`RLVD_EXT_DIV_4) : 16'(`RLVD_INT_MS_4 / `RLVD_OSC_TICK_MS);
      3'h5: dly_limit = ext ? 16'(`RLVD_EXT_DIV_5) : 16'(`RLVD_INT_MS_5 / `RLVD_OSC_TICK_MS);
      3'h6: dly_limit = ext ? 16'(`RLVD_EXT_DIV_6) : 16'(`RLVD_INT_MS_6 / `RLVD_OSC_TICK_MS);
      3'h7: dly_limit = ext ? 16'(`RLVD_EXT_DIV_7) : 16'(`RLVD_INT_MS_7 / `RLVD_OSC_TICK_MS);
      default: dly_limit = 16'h0001;
    endcase
  endfunction : dly_limit

  // RULE_03 source picks tick
  assign tick = (tif.clk_src == rlvd_pkg::rlvd_src_ext) ? tif.tick_ext : tif.tick_int;
  assign limit = dly_limit(tif.clk_src, tif.delay_sel);
  assign tif.timeout = timeout_ff;

  // RULE_05 code zero halts
  // RULE_18 wrap and restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else if (tif.restart || tif.delay_sel == 3'h0) begin
      cnt_ff <= 16'h0000;
    end else if (tick) begin
      cnt_ff <= (cnt_ff == limit - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  // RULE_06 internal delay end
  // RULE_07 external delay end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= !tif.restart && tif.delay_sel != 3'h0 && tick && cnt_ff == limit - 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dly_zero_quiet: assert property (tif.delay_sel == 3'h0 |=> !timeout_ff) // RULE_05
    else $error("timeout with delay code zero");
  a_tmr_limit_hit: assert property ( // RULE_18
    !tif.restart && tif.delay_sel != 3'h0 && tick && cnt_ff == limit - 16'h0001 |=> timeout_ff && cnt_ff == 16'h0000)
    else $error("timer missed end of delay");
  a_restart_clears: assert property (tif.restart |=> cnt_ff == 16'h0000 && !timeout_ff) // RULE_18
    else $error("restart did not clear count");
  c_tmr_ext_timeout: cover property (timeout_ff && tif.clk_src == rlvd_pkg::rlvd_src_ext);

endmodule : rlvd_wakeup_timer
`default_nettype wire
